// [logic/p2g_port.v]
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "p2g_regs.vh"

// ****************************************************************
// Eight-pin general port that may also drive address bits 15 to 8.
// ****************************************************************
module p2g_port (
    input  wire        clk,
    input  wire        rst,
    // Avalon-MM slave, word addressed by register index.
    input  wire [15:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [3:0]  avs_byteenable,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Operating mode straps and standby controls.
    input  wire [1:0]  mode_pins,
    input  wire        hw_standby,
    input  wire        sw_standby,
    // Upper byte of the lower address word from the bus controller.
    input  wire [7:0]  upper_low_address_byte,
    // Port pins.
    input  wire [7:0]  pin_in,
    output wire [7:0]  pin_out,
    output wire [7:0]  pin_oe,
    output wire [7:0]  pullup_on
);

    // ****************************************************************
    // Bus handshake states.
    // ****************************************************************
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ANS  = 1'b1;

    // ****************************************************************
    // Shared helpers.
    // ****************************************************************
    function is_reg;
        input [15:0] addr;
        input [15:0] idx;
        begin
            is_reg = (addr == idx);
        end
    endfunction

    // Per-pin merge: where sel is 1 take a, otherwise take b.
    function [7:0] merge8;
        input [7:0] sel;
        input [7:0] a;
        input [7:0] b;
        begin
            merge8 = (sel & a) | (~sel & b);
        end
    endfunction

    // Zero-extends one register byte onto the 32-bit read bus.
    function [31:0] widen8;
        input [7:0] value;
        begin
            widen8 = {24'h000000, value};
        end
    endfunction

    // ****************************************************************
    // Synchronised pin inputs.
    // ****************************************************************
    wire [10:0] sync_bus;
    wire [7:0]  pin_sync;
    wire [1:0]  mode_sync;
    wire        hws_sync;

    p2g_sync #(
        .WIDTH    (11)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({hw_standby, mode_pins, pin_in}),
        .sync_out (sync_bus)
    );

    assign pin_sync  = sync_bus[7:0];
    assign mode_sync = sync_bus[9:8];
    assign hws_sync  = sync_bus[10];

    // ****************************************************************
    // Mode decode.
    // ****************************************************************
    wire expanded;
    wire clear_all;

    assign expanded  = (mode_sync == `P2G_MODE_EXPANDED);
    // Hardware standby acts like reset on the control and pin drive registers, but not on the bus slave state.
    assign clear_all = rst | hws_sync;

    // ****************************************************************
    // Register bus slave.
    // ****************************************************************
    reg        bus_state_r;
    reg        bus_state_nxt;
    reg        wait_r;
    reg        wait_nxt;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    reg [7:0]  dir_r;
    reg [7:0]  dir_nxt;
    reg [7:0]  data_r;
    reg [7:0]  data_nxt;
    reg [7:0]  pull_r;
    reg [7:0]  pull_nxt;
    reg [7:0]  out_r;
    reg [7:0]  out_nxt;
    reg [7:0]  oe_r;
    reg [7:0]  oe_nxt;
    reg [7:0]  pu_r;
    reg [7:0]  pu_nxt;

    wire       req;
    wire       commit;
    wire       wr_ok;
    wire [7:0] wbyte;
    wire       take;
    wire       hit_dir;
    wire       hit_data;
    wire       hit_pull;
    wire       wr_dir;
    wire       wr_data;
    wire       wr_pull;

    assign req    = avs_read | avs_write;
    // A write lands at the edge where waitrequest is seen low.
    assign commit = (bus_state_r == BUS_ANS) & avs_write;
    // Registers stay frozen while the core sleeps in software standby.
    assign wr_ok  = commit & avs_byteenable[0] & ~sw_standby;
    assign wbyte  = avs_writedata[7:0];

    // A request is taken only while the slave is idle.
    assign take   = (bus_state_r == BUS_IDLE) & req;

    // The full index is decoded, as neighbouring ports share the same page.
    assign hit_dir  = is_reg(avs_address, `P2G_IDX_DIR);
    assign hit_data = is_reg(avs_address, `P2G_IDX_DATA);
    assign hit_pull = is_reg(avs_address, `P2G_IDX_PULLUP);
    assign wr_dir   = wr_ok & hit_dir;
    assign wr_data  = wr_ok & hit_data;
    assign wr_pull  = wr_ok & hit_pull;

    always @* begin
        bus_state_nxt = bus_state_r;
        wait_nxt      = 1'b1;
        case (bus_state_r)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_nxt = BUS_ANS;
                    wait_nxt      = 1'b0;
                end
            end
            BUS_ANS: begin
                bus_state_nxt = BUS_IDLE;
                wait_nxt      = 1'b1;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // Read data are captured with the answer and held until the next read.
    always @* begin
        rdata_nxt = rdata_r;
        if (take && avs_read) begin
            if (hit_dir) begin
                rdata_nxt = widen8(`P2G_DIR_READBACK);
            end else if (hit_data) begin
                rdata_nxt = widen8(merge8(dir_r, data_r, pin_sync));
            end else if (hit_pull) begin
                rdata_nxt = widen8(pull_r);
            end else begin
                rdata_nxt = `P2G_UNMAPPED_READ;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            bus_state_r <= BUS_IDLE;
            wait_r      <= 1'b1;
            rdata_r     <= `P2G_UNMAPPED_READ;
        end else begin
            bus_state_r <= bus_state_nxt;
            wait_r      <= wait_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Direction, data latch and pull-up control registers.
    // ****************************************************************
    always @* begin
        dir_nxt = dir_r;
        if (wr_dir) begin
            dir_nxt = wbyte;
        end
    end

    always @* begin
        data_nxt = data_r;
        if (wr_data) begin
            data_nxt = wbyte;
        end
    end

    always @* begin
        pull_nxt = pull_r;
        if (wr_pull) begin
            pull_nxt = wbyte;
        end
    end

    // Software standby needs no branch here: no write is accepted then.
    always @(posedge clk) begin
        if (clear_all) begin
            dir_r <= `P2G_RST_DIR;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    always @(posedge clk) begin
        if (clear_all) begin
            data_r <= `P2G_RST_DATA;
        end else begin
            data_r <= data_nxt;
        end
    end

    always @(posedge clk) begin
        if (clear_all) begin
            pull_r <= `P2G_RST_PULLUP;
        end else begin
            pull_r <= pull_nxt;
        end
    end

    // ****************************************************************
    // Pin drive and pull-up control.
    // ****************************************************************
    always @* begin
        oe_nxt  = dir_r;
        out_nxt = {8{1'b0}};
        if (expanded) begin
            out_nxt = dir_r & upper_low_address_byte;
        end else begin
            out_nxt = dir_r & data_r;
        end
        // Address lines would otherwise toggle with a stopped bus.
        if (sw_standby) begin
            oe_nxt  = oe_r;
            out_nxt = out_r;
        end
    end

    always @* begin
        pu_nxt = pull_r & ~dir_r;
        if (sw_standby) begin
            pu_nxt = pu_r;
        end
    end

    // Enables drop with reset so that no pin fights the board while it comes up.
    always @(posedge clk) begin
        if (clear_all) begin
            oe_r <= `P2G_RST_DIR;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    always @(posedge clk) begin
        if (clear_all) begin
            out_r <= `P2G_RST_DATA;
        end else begin
            out_r <= out_nxt;
        end
    end

    always @(posedge clk) begin
        if (clear_all) begin
            pu_r <= `P2G_RST_PULLUP;
        end else begin
            pu_r <= pu_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pin_out         = out_r;
    assign pin_oe          = oe_r;
    assign pullup_on       = pu_r;

endmodule

`default_nettype wire

// [logic/p2g_regs.vh]
// How it works
// - Expanded mode: direction 1 address, 0 input.
// - Expanded pins carry address bits 15 to 8.
// - Single-chip modes: direction 1 output, 0 input.
// - Direction register reads back all ones.
// - Direction clears on reset, hardware standby.
// - Software standby keeps driven pins' output state.
// - Data read: latch if output, else pin.
// - Data latch read/write, clears, survives software standby.
// - Pull-up on only when selected and input.
// - Each pull-up has its own control bit.
// - Pull-up control read/write, clears, survives software standby.
// - Pull-ups off in reset, hardware standby.
// - Registers at FFC1, FFC3 and FFD8.
`ifndef P2G_REGS_VH
`define P2G_REGS_VH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define P2G_IDX_DIR       16'hffc1
`define P2G_IDX_DATA      16'hffc3
`define P2G_IDX_PULLUP    16'hffd8

// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define P2G_PORT_LSB      0
`define P2G_PORT_MSB      7
`define P2G_RST_DIR       8'h00
`define P2G_RST_DATA      8'h00
`define P2G_RST_PULLUP    8'h00
`define P2G_DIR_READBACK  8'hff
`define P2G_UNMAPPED_READ 32'h0000_0000

// ****************************************************************
// Operating modes.
// ****************************************************************
`define P2G_MODE_EXPANDED 2'h1
`define P2G_MODE_SINGLE2  2'h2
`define P2G_MODE_SINGLE3  2'h3

`endif

// [logic/p2g_sync.v]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for levels arriving from outside.
// ****************************************************************
module p2g_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // The first stage is read only by the second stage.
    always @(posedge clk) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

`default_nettype wire

// [verification/p2g_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "p2g_regs.vh"
// ********
// Checker
// ********
module p2g_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        hw_standby,
    input wire logic        sw_standby,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pullup_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_pull; (pullup_on & pin_oe) == 8'h00; endproperty
    a_pull: assert property (p_pull) else $error("pull-up on driven pin");
    property p_out; (pin_out & ~pin_oe) == 8'h00; endproperty
    a_out: assert property (p_out) else $error("value on undriven pin");
    property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("answer too long");
    property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_rst; $past(rst) |-> pin_oe == 8'h00 && pullup_on == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pins not cleared");
    property p_sw; sw_standby && $past(sw_standby) |-> $stable(pin_oe) && $stable(pin_out); endproperty
    a_sw: assert property (p_sw) else $error("pins moved in standby");
    property p_hw; hw_standby [*4] |=> pin_oe == 8'h00 && pullup_on == 8'h00; endproperty
    a_hw: assert property (p_hw) else $error("standby did not clear");
    property p_dir;
        avs_read && avs_waitrequest && avs_address == `P2G_IDX_DIR |=> avs_readdata == 32'h0000_00ff;
    endproperty
    a_dir: assert property (p_dir) else $error("direction read not ones");
    property p_wroe;
        avs_write && !avs_waitrequest && avs_byteenable[0] && !sw_standby && avs_address == `P2G_IDX_DIR
            |=> ##1 pin_oe == $past(avs_writedata[7:0], 2);
    endproperty
    a_wroe: assert property (p_wroe) else $error("enable not direction");
    c_pull: cover property (pullup_on != 8'h00);
    c_sw: cover property (sw_standby && pin_oe != 8'h00);
    c_hw: cover property (hw_standby [*4]);
endmodule
`default_nettype wire

// [verification/p2g_pins.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************
// Pin wiring model
// ****************
module p2g_pins (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_drv,
    output var  logic [7:0] pin_level
);
    logic [7:0] noise_r = 8'h55;
    // Floating pins toggle so a stale level never passes for a match.
    always @(posedge clk) noise_r <= ~noise_r;
    always_comb
        for (int i = 0; i < 8; i++)
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pullup_on[i] | noise_r[i];
endmodule
`default_nettype wire

// [verification/test_p2g_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "p2g_regs.vh"
// **********
// Testbench
// **********
module test_p2g_port;
    localparam logic [15:0] a_dir = `P2G_IDX_DIR;
    localparam logic [15:0] a_dat = `P2G_IDX_DATA;
    localparam logic [15:0] a_pul = `P2G_IDX_PULLUP;
    logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, hw_standby = 0, sw_standby = 0, avs_waitrequest;
    logic [15:0] avs_address = 0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [1:0] mode_pins = 2'h2;
    logic [7:0] adr = 0, ext_val = 8'h3c, ext_drv = 8'hff, pin_level, pin_out, pin_oe, pullup_on;
    int err_count = 0, compares = 0;
    always #10 clk = ~clk;
    p2g_port p2g_port_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mode_pins(mode_pins),
        .hw_standby(hw_standby), .sw_standby(sw_standby), .upper_low_address_byte(adr),
        .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));
    p2g_pins p2g_pins_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .ext_val(ext_val), .ext_drv(ext_drv), .pin_level(pin_level));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("CHECK FAILED waitrequest expected 0 seen 1");
            tally_and_finish();
        end
    endtask
    task automatic rdchk(string nm, logic [15:0] a, logic [31:0] e);
        bus(0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_single();
        for (int m = 2; m < 4; m++) begin
            mode_pins <= m[1:0];
            bus(1, a_dir, 8'h0f);
            bus(1, a_dat, 8'ha5);
            tick(3);
            chk("oe", 8'h0f, pin_oe);
            chk("out", 8'h05, pin_out);
            rdchk("data", a_dat, 32'h35);
            rdchk("dir", a_dir, 32'hff);
        end
        bus(1, a_pul, 8'hc3);
        tick(2);
        chk("pull", 8'hc0, pullup_on);
        rdchk("pcr", a_pul, 32'hc3);
        ext_drv <= 8'h0f;
        tick(4);
        bus(0, a_dat, 8'h00);
        chk("float", 32'hc5, q & 32'hcf);
        ext_drv <= 8'hff;
        bus(1, a_pul, 8'h30);
        tick(2);
        chk("pull", 8'h30, pullup_on);
        $display("test single done");
    endtask
    task automatic t_exp();
        mode_pins <= 2'h1;
        adr <= 8'h5a;
        tick(3);
        bus(1, a_dir, 8'h0f);
        tick(2);
        chk("oe", 8'h0f, pin_oe);
        chk("out", 8'h0a, pin_out);
        adr <= 8'ha5;
        tick(2);
        chk("out", 8'h05, pin_out);
        $display("test expanded done");
    endtask
    task automatic t_stby();
        sw_standby <= 1'b1;
        bus(1, a_dir, 8'hf0);
        bus(1, a_pul, 8'h00);
        tick(2);
        chk("oe", 8'h0f, pin_oe);
        chk("pull", 8'h30, pullup_on);
        sw_standby <= 1'b0;
        rdchk("pcr", a_pul, 32'h30);
        rdchk("data", a_dat, 32'h35);
        bus(1, 16'hffc2, 8'hff);
        rdchk("gap", 16'hffc2, 32'h0);
        hw_standby <= 1'b1;
        tick(6);
        chk("oe", 8'h00, pin_oe);
        chk("pull", 8'h00, pullup_on);
        hw_standby <= 1'b0;
        tick(4);
        rdchk("pcr", a_pul, 32'h0);
        bus(1, a_dir, 8'hff);
        rdchk("data", a_dat, 32'h0);
        avs_byteenable <= 4'h0;
        bus(1, a_dat, 8'hff);
        avs_byteenable <= 4'h1;
        rdchk("data", a_dat, 32'h0);
        bus(1, a_dir, 8'h00);
        bus(1, a_pul, 8'h0f);
        tick(2);
        chk("pull", 8'h0f, pullup_on);
        rst <= 1'b1;
        tick(3);
        chk("oe", 8'h00, pin_oe);
        chk("pull", 8'h00, pullup_on);
        rst <= 1'b0;
        tick(3);
        rdchk("pcr", a_pul, 32'h0);
        rdchk("data", a_dat, 32'h3c);
        $display("test standby done");
    endtask
    initial begin
        tick(10);
        rst <= 1'b0;
        rdchk("dir", a_dir, 32'hff);
        rdchk("data", a_dat, 32'h3c);
        t_single();
        t_exp();
        t_stby();
        tally_and_finish();
    end
endmodule
bind p2g_port p2g_checker p2g_checker_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on));
`default_nettype wire
